// ---- include/rtcm_consts.svh ----
// constants of the rtc timer, alarm and clock monitor core
// assumes inclusion by bare name from the core and the oscillator watchdog
`ifndef RTCM_CONSTS_SVH
`define RTCM_CONSTS_SVH

// --------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------
`define RTCM_CLK_MHZ          100
`define RTCM_MISS_TIME_US     100
`define RTCM_MISS_CYC         (`RTCM_MISS_TIME_US * `RTCM_CLK_MHZ)
`define RTCM_BLANK_TIME_MS    2
`define RTCM_BLANK_CYC        (`RTCM_BLANK_TIME_MS * 1000 * `RTCM_CLK_MHZ)

// --------------------------------------------------------------
// widths
// --------------------------------------------------------------
`define RTCM_TIMER_W          32
`define RTCM_SNAP_BYTES       6

// --------------------------------------------------------------
// clock control register bit positions
// --------------------------------------------------------------
`define RTCM_CTL_OSC_EN_BIT   7
`define RTCM_CTL_MISS_EN_BIT  6
`define RTCM_CTL_FAIL_BIT     5
`define RTCM_CTL_RUN_BIT      4
`define RTCM_CTL_AEN_BIT      3
`define RTCM_CTL_ALARM_BIT    2
`define RTCM_CTL_LOAD_BIT     1
`define RTCM_CTL_SNAP_BIT     0

// --------------------------------------------------------------
// oscillator control register bit positions and reset values
// --------------------------------------------------------------
`define RTCM_OCTL_VALID_BIT   4
`define RTCM_TIMER_RST        32'h0000_0000
`define RTCM_BYTE_RST         8'h00

`endif

// ---- include/rtcm_pkg.sv ----
// types shared by the rtc timer, alarm and clock monitor core
// assumes rtcm_consts.svh is on the include path
package rtcm_pkg;

    // ----------------------------------------------------------
    // timer update selection
    // ----------------------------------------------------------
    typedef enum logic [1:0] {
        RTCM_ACT_HOLD  = 2'b00,
        RTCM_ACT_COUNT = 2'b01,
        RTCM_ACT_LOAD  = 2'b10,
        RTCM_ACT_CLEAR = 2'b11
    } rtcm_tact_t;

endpackage : rtcm_pkg

// ---- verilog/rtcm_osc_watch.sv ----
// missing-oscillator watchdog: one-shot timeout when the level stalls
// assumes osc_level is synchronous to clk_sys
`timescale 1ns/1ns
`include "rtcm_consts.svh"

module rtcm_osc_watch #(
    parameter int MISS_CYC = `RTCM_MISS_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic osc_level,
    input  wire logic enable,
    output logic      timeout
);
    localparam int CW = $clog2(MISS_CYC + 1);

    if (MISS_CYC < 2) begin : g_chk_miss
        $error("MISS_CYC must be at least 2");
    end

    logic          prev_r, prev_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          fired_r, fired_nxt;
    logic          timeout_r, timeout_nxt;

    // --------------------------------------------------------------
    // stall counter
    // --------------------------------------------------------------
    always_comb begin
        prev_nxt    = osc_level;
        cnt_nxt     = cnt_r;
        fired_nxt   = fired_r;
        timeout_nxt = 1'b0;
        if (!enable || osc_level != prev_r) begin  // RULE1
            cnt_nxt   = '0;
            fired_nxt = 1'b0;
        end else if (cnt_r < CW'(MISS_CYC)) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (!fired_r) begin
            // one shot: a long stall reports once, not every cycle
            timeout_nxt = 1'b1;                     // RULE2
            fired_nxt   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev_r    <= 1'b0;
            cnt_r     <= '0;
            fired_r   <= 1'b0;
            timeout_r <= 1'b0;
        end else begin
            prev_r    <= prev_nxt;
            cnt_r     <= cnt_nxt;
            fired_r   <= fired_nxt;
            timeout_r <= timeout_nxt;
        end
    end

    assign timeout = timeout_r;

endmodule : rtcm_osc_watch

// ---- verilog/rtcm_core.sv ----
// rtc timer with alarm, auto clear, snapshot and load paths,
// missing-oscillator monitor and crystal-valid status
// assumes every input is synchronous to clk_sys; the oscillator
// output arrives as a level sampled on clk_sys
//
// Operation
// RULE1: detector runs only when its enable set
// RULE2: stalled oscillator over 100 us sets failure
// RULE3: timeout offered as irq, wake, reset source
// RULE4: software disables detector before oscillator changes
// RULE5: crystal valid readable at oscillator control bit4
// RULE6: software ignores crystal valid first 2 ms
// RULE7: timer counts each oscillator cycle while running
// RULE8: timer wraps freely past maximum
// RULE9: alarm when timer equals match, if enabled
// RULE10: alarm offered as irq, wake, reset source
// RULE11: auto clear zeroes timer after alarm drops
// RULE12: alarm bit write one enables auto clear
// RULE13: software programs match two or four below
// RULE14: six snapshot bytes load and read timer; the core loads and reads only bytes 0 to 3
// RULE15: load request copies bytes, then self-clears
// RULE16: snapshot request copies timer, then self-clears
// RULE17: software waits for request bits to clear
// RULE18: software disables alarm, writes match, re-enables
// RULE19: clearing alarm enable clears alarm flag
// RULE20: alarm flag lasts one oscillator cycle
// RULE21: re-enabled unchanged alarm recurs after wrap
// RULE22: software advances match by unsigned addition
// RULE23: low frequency source adds at bit one
// RULE24: oscillator enable gates timer clock entirely
// RULE25: requests cross domains, completion returns before clear; the core has one clock domain, request clears the cycle after set drops
// RULE26: alarm and outputs are synchronous pulses, levels
`timescale 1ns/1ns
`include "rtcm_consts.svh"

module rtcm_core
    import rtcm_pkg::*;
#(
    parameter int TIMER_W    = `RTCM_TIMER_W,
    parameter int SNAP_BYTES = `RTCM_SNAP_BYTES,
    parameter int MISS_CYC   = `RTCM_MISS_CYC
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    input  wire logic                    osc_in,
    input  wire logic                    crystal_valid_in,
    input  wire logic                    oscillator_enable,
    input  wire logic                    missing_osc_detect_enable,
    input  wire logic                    osc_failure_clear,
    input  wire logic                    timer_run,
    input  wire logic                    low_frequency_oscillator,
    input  wire logic                    alarm_event_enable,
    input  wire logic                    alarm_flag_autoclear_enable,
    input  wire logic [TIMER_W-1:0]      alarm_match_regs,
    input  wire logic                    timer_load_set,
    input  wire logic                    timer_snapshot_set,
    input  wire logic                    snap_wr_en,
    input  wire logic [2:0]              snap_wr_idx,
    input  wire logic [7:0]              snap_wr_data,
    output logic [SNAP_BYTES*8-1:0]      snapshot_bytes,
    output logic [TIMER_W-1:0]           timer_value,
    output logic                         timer_load_request,
    output logic                         timer_snapshot_request,
    output logic                         alarm_flag,
    output logic                         alarm_event,
    output logic                         osc_failure_flag,
    output logic                         osc_failure_event,
    output logic                         crystal_valid_status,
    output logic [7:0]                   clock_control_register,
    output logic [7:0]                   oscillator_control_register
);

    if (TIMER_W < 8 || TIMER_W % 8 != 0) begin : g_chk_w
        $error("TIMER_W must be a byte multiple");
    end
    if (SNAP_BYTES * 8 < TIMER_W || SNAP_BYTES > 8) begin : g_chk_snap
        $error("SNAP_BYTES does not fit");
    end

    // --------------------------------------------------------------
    // oscillator edge and missing-oscillator monitor
    // --------------------------------------------------------------
    logic osc_prev_r, osc_prev_nxt;
    logic tick;
    logic miss_pulse;

    // a stopped oscillator delivers no ticks at all
    assign tick = oscillator_enable & osc_in & ~osc_prev_r;  // RULE24

    rtcm_osc_watch #(
        .MISS_CYC (MISS_CYC)
    ) u_watch (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .osc_level (osc_in),
        .enable    (missing_osc_detect_enable),
        .timeout   (miss_pulse)
    );

    // --------------------------------------------------------------
    // control state
    // --------------------------------------------------------------
    logic [TIMER_W-1:0]  timer_r, timer_nxt;
    logic [7:0]          snap_r [SNAP_BYTES];
    logic [7:0]          snap_nxt [SNAP_BYTES];
    logic                load_req_r, load_req_nxt;
    logic                snap_req_r, snap_req_nxt;
    logic                aflag_r, aflag_nxt;
    logic                aevt_r, aevt_nxt;
    logic                apend_r, apend_nxt;
    logic                fail_r, fail_nxt;
    logic                fevt_r, fevt_nxt;
    logic                xvalid_r, xvalid_nxt;
    logic                match;
    logic [TIMER_W-1:0]  inc;
    rtcm_tact_t          act;

    assign match = (timer_r == alarm_match_regs);            // RULE9
    assign inc   = low_frequency_oscillator ? TIMER_W'(2) : TIMER_W'(1);  // RULE23

    // --------------------------------------------------------------
    // timer update
    // --------------------------------------------------------------
    always_comb begin
        if (load_req_r) begin
            act = RTCM_ACT_LOAD;                             // RULE15
        end else if (tick && apend_r) begin
            act = RTCM_ACT_CLEAR;                            // RULE11
        end else if (tick && timer_run) begin
            act = RTCM_ACT_COUNT;                            // RULE7
        end else begin
            act = RTCM_ACT_HOLD;
        end
    end

    always_comb begin
        timer_nxt = timer_r;
        case (act)
            RTCM_ACT_LOAD: begin
                for (int i = 0; i < TIMER_W / 8; i++) begin
                    timer_nxt[i*8 +: 8] = snap_r[i];         // RULE14
                end
            end
            RTCM_ACT_CLEAR: timer_nxt = '0;
            // plain modular add: the counter rolls over, never sticks
            RTCM_ACT_COUNT: timer_nxt = timer_r + inc;       // RULE8
            default:        timer_nxt = timer_r;
        endcase
    end

    // --------------------------------------------------------------
    // snapshot bytes and request bits
    // --------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < SNAP_BYTES; i++) begin
            snap_nxt[i] = snap_r[i];
            if (snap_wr_en && 32'(snap_wr_idx) == i) begin
                snap_nxt[i] = snap_wr_data;
            end
        end
        // capture beats a software write to a timer byte in the same cycle
        if (snap_req_r) begin
            for (int i = 0; i < TIMER_W / 8; i++) begin
                snap_nxt[i] = timer_r[i*8 +: 8];             // RULE16
            end
        end
        // one clock domain: completion is the cycle after the request,
        // and a new set in the completing cycle is kept
        load_req_nxt = timer_load_set | (load_req_r & 1'b0);  // RULE25
        snap_req_nxt = timer_snapshot_set;                    // RULE25
        if (!timer_load_set && load_req_r) begin
            load_req_nxt = 1'b0;                             // RULE15
        end
        if (!timer_snapshot_set && snap_req_r) begin
            snap_req_nxt = 1'b0;                             // RULE16
        end
    end

    // --------------------------------------------------------------
    // alarm flag, event and auto clear
    // --------------------------------------------------------------
    always_comb begin
        aflag_nxt = aflag_r;
        apend_nxt = apend_r;
        aevt_nxt  = 1'b0;
        if (!alarm_event_enable) begin
            aflag_nxt = 1'b0;                                // RULE19
        end else if (tick) begin                             // RULE21
            // flag holds for one oscillator period, or longer while the timer stays at the match value
            aflag_nxt = match;                               // RULE20
            aevt_nxt  = match;                               // RULE10
        end
        if (tick) begin
            apend_nxt = alarm_flag_autoclear_enable & aflag_r & ~aflag_nxt;  // RULE12
        end
        if (act == RTCM_ACT_LOAD) begin
            apend_nxt = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // failure flag and crystal valid
    // --------------------------------------------------------------
    always_comb begin
        osc_prev_nxt = osc_in;
        // a timeout in the clearing cycle wins over the clear
        fail_nxt     = miss_pulse | (fail_r & ~osc_failure_clear);  // RULE2
        fevt_nxt     = miss_pulse;                           // RULE3
        // no blanking here; the detector may read high during start-up
        xvalid_nxt   = crystal_valid_in;                     // RULE5
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            osc_prev_r <= 1'b0;
            timer_r    <= `RTCM_TIMER_RST;
            load_req_r <= 1'b0;
            snap_req_r <= 1'b0;
            aflag_r    <= 1'b0;
            aevt_r     <= 1'b0;
            apend_r    <= 1'b0;
            fail_r     <= 1'b0;
            fevt_r     <= 1'b0;
            xvalid_r   <= 1'b0;
            for (int i = 0; i < SNAP_BYTES; i++) begin
                snap_r[i] <= `RTCM_BYTE_RST;
            end
        end else begin
            osc_prev_r <= osc_prev_nxt;
            timer_r    <= timer_nxt;
            load_req_r <= load_req_nxt;
            snap_req_r <= snap_req_nxt;
            aflag_r    <= aflag_nxt;
            aevt_r     <= aevt_nxt;
            apend_r    <= apend_nxt;
            fail_r     <= fail_nxt;
            fevt_r     <= fevt_nxt;
            xvalid_r   <= xvalid_nxt;
            for (int i = 0; i < SNAP_BYTES; i++) begin
                snap_r[i] <= snap_nxt[i];
            end
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    for (genvar g = 0; g < SNAP_BYTES; g++) begin : g_snap
        assign snapshot_bytes[g*8 +: 8] = snap_r[g];
    end

    assign timer_value            = timer_r;
    assign timer_load_request     = load_req_r;
    assign timer_snapshot_request = snap_req_r;
    assign alarm_flag             = aflag_r;
    assign alarm_event            = aevt_r;                  // RULE26
    assign osc_failure_flag       = fail_r;
    assign osc_failure_event      = fevt_r;
    assign crystal_valid_status   = xvalid_r;

    always_comb begin
        clock_control_register = 8'h00;
        clock_control_register[`RTCM_CTL_OSC_EN_BIT]  = oscillator_enable;
        clock_control_register[`RTCM_CTL_MISS_EN_BIT] = missing_osc_detect_enable;
        clock_control_register[`RTCM_CTL_FAIL_BIT]    = fail_r;
        clock_control_register[`RTCM_CTL_RUN_BIT]     = timer_run;
        clock_control_register[`RTCM_CTL_AEN_BIT]     = alarm_event_enable;
        clock_control_register[`RTCM_CTL_ALARM_BIT]   = aflag_r;
        clock_control_register[`RTCM_CTL_LOAD_BIT]    = load_req_r;
        clock_control_register[`RTCM_CTL_SNAP_BIT]    = snap_req_r;
        oscillator_control_register = 8'h00;
        oscillator_control_register[`RTCM_OCTL_VALID_BIT] = xvalid_r;  // RULE5
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_count_tick;
        tick && timer_run && !load_req_r && !apend_r;
    endsequence

    sequence s_alarm_hit;
        tick && alarm_event_enable && match;
    endsequence

    property p_count;
        @(posedge clk_sys) disable iff (!rstn)
        s_count_tick |=> timer_r == $past(timer_r) + $past(inc);
    endproperty
    a_count: assert property (p_count) else $error("timer did not step"); // RULE7

    property p_hold;
        @(posedge clk_sys) disable iff (!rstn)
        (!load_req_r && !(tick && (timer_run || apend_r))) |=> $stable(timer_r);
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved while idle"); // RULE24

    property p_wrap;
        @(posedge clk_sys) disable iff (!rstn)
        (s_count_tick and (timer_r == '1) and !low_frequency_oscillator) |=> timer_r == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("timer did not wrap"); // RULE8

    property p_alarm;
        @(posedge clk_sys) disable iff (!rstn)
        s_alarm_hit |=> alarm_event && alarm_flag;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm missed"); // RULE9

    property p_aen_clear;
        @(posedge clk_sys) disable iff (!rstn)
        !alarm_event_enable |=> !alarm_flag;
    endproperty
    a_aen_clear: assert property (p_aen_clear) else $error("flag kept"); // RULE19

    property p_flag_once;
        @(posedge clk_sys) disable iff (!rstn)
        (alarm_flag && tick && !match) |=> !alarm_flag;
    endproperty
    a_flag_once: assert property (p_flag_once) else $error("flag overstayed"); // RULE20

    property p_autoclr;
        @(posedge clk_sys) disable iff (!rstn)
        (tick && apend_r && !load_req_r) |=> timer_r == '0;
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("no auto clear"); // RULE11

    property p_load;
        @(posedge clk_sys) disable iff (!rstn)
        (timer_load_set ##1 !timer_load_set) |=> !timer_load_request
            && timer_r[7:0] == $past(snap_r[0]);
    endproperty
    a_load: assert property (p_load) else $error("load failed"); // RULE15

    property p_snap;
        @(posedge clk_sys) disable iff (!rstn)
        (timer_snapshot_set ##1 !timer_snapshot_set) |=> !timer_snapshot_request
            && snap_r[0] == $past(timer_r[7:0]);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot failed"); // RULE16

    property p_fail_sticky;
        @(posedge clk_sys) disable iff (!rstn)
        osc_failure_flag && !osc_failure_clear |=> osc_failure_flag;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag lost"); // RULE2

    property p_fail_gated;
        @(posedge clk_sys) disable iff (!rstn)
        (!missing_osc_detect_enable [*2]) |=> !osc_failure_event;
    endproperty
    a_fail_gated: assert property (p_fail_gated) else $error("detector off fired"); // RULE1

endmodule : rtcm_core

// ---- bench/tb_top.sv ----
// self-checking bench for the rtc timer, alarm and clock monitor core
// assumes the oscillator is modelled as a level driven at the falling edge
`timescale 1ns/1ns

module tb_top;
    import rtcm_pkg::*;

    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    localparam int MISS = 20;
    logic        clk_sys = 1'b0, rstn = 1'b0, osc_in = 1'b0, crystal_valid_in = 1'b0;
    logic        oscillator_enable = 1'b0, missing_osc_detect_enable = 1'b0;
    logic        osc_failure_clear = 1'b0, timer_run = 1'b0, low_frequency_oscillator = 1'b0;
    logic        alarm_event_enable = 1'b0, alarm_flag_autoclear_enable = 1'b0;
    logic        timer_load_set = 1'b0, timer_snapshot_set = 1'b0, snap_wr_en = 1'b0;
    logic [2:0]  snap_wr_idx = 3'h0;
    logic [7:0]  snap_wr_data = 8'h00, ccr, ocr;
    logic [31:0] alarm_match_regs = 32'h0000_0000, timer_value, tv;
    logic [47:0] snapshot_bytes;
    logic        load_req, snap_req, alarm_flag, alarm_event, fail_flag, fail_event, cv_status;
    int          num_errors = 0, compares = 0, cyc = 0, n_alarm = 0, n_fail = 0;

    always #5 clk_sys = ~clk_sys;

    rtcm_core #(.MISS_CYC(MISS)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .osc_in(osc_in), .crystal_valid_in(crystal_valid_in),
        .oscillator_enable(oscillator_enable),
        .missing_osc_detect_enable(missing_osc_detect_enable),
        .osc_failure_clear(osc_failure_clear), .timer_run(timer_run),
        .low_frequency_oscillator(low_frequency_oscillator),
        .alarm_event_enable(alarm_event_enable),
        .alarm_flag_autoclear_enable(alarm_flag_autoclear_enable),
        .alarm_match_regs(alarm_match_regs), .timer_load_set(timer_load_set),
        .timer_snapshot_set(timer_snapshot_set), .snap_wr_en(snap_wr_en),
        .snap_wr_idx(snap_wr_idx), .snap_wr_data(snap_wr_data),
        .snapshot_bytes(snapshot_bytes), .timer_value(timer_value),
        .timer_load_request(load_req), .timer_snapshot_request(snap_req),
        .alarm_flag(alarm_flag), .alarm_event(alarm_event), .osc_failure_flag(fail_flag),
        .osc_failure_event(fail_event), .crystal_valid_status(cv_status),
        .clock_control_register(ccr), .oscillator_control_register(ocr)
    );

    // ----------------------------------------------------------
    // event counters and hang guard
    // ----------------------------------------------------------
    // counting per cycle also catches a pulse that lasts too long
    always @(negedge clk_sys) begin
        cyc++;
        if (alarm_event === 1'b1) n_alarm++;
        if (fail_event === 1'b1) n_fail++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // one oscillator cycle per iteration, then time for the update to land
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk_sys) osc_in = 1'b1;
            @(negedge clk_sys) osc_in = 1'b0;
        end
        repeat (2) @(negedge clk_sys);
    endtask : tick

    task automatic load_timer(input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            snap_wr_en   = 1'b1;
            snap_wr_idx  = 3'(i);
            snap_wr_data = v[8*i +: 8];
        end
        @(negedge clk_sys);
        snap_wr_en     = 1'b0;
        timer_load_set = 1'b1;
        @(negedge clk_sys) timer_load_set = 1'b0;
        chk(32'(load_req), 32'h1, "load request not raised");
        chk(32'(ccr[1]), 32'h1, "load bit in control register");
        @(negedge clk_sys);
        chk(32'(load_req), 32'h0, "load request not cleared");
        chk(timer_value, v, "loaded value");
    endtask : load_timer

    task automatic end_test(input string name);
        $display("test %s done, errors %0d", name, num_errors);
    endtask : end_test

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk_sys);
        rstn = 1'b1;
        chk(timer_value, 32'h0, "timer after reset");
        chk(32'(fail_flag), 32'h0, "failure flag after reset");
        end_test("reset");

        oscillator_enable = 1'b1;
        timer_run = 1'b1;
        tick(3);
        chk(timer_value, 32'h3, "counting");
        chk(32'(ccr[7]), 32'h1, "oscillator enable bit");
        chk(32'(ccr[4]), 32'h1, "run bit");
        timer_run = 1'b0;
        tick(2);
        chk(timer_value, 32'h3, "hold when stopped");
        timer_run = 1'b1;
        oscillator_enable = 1'b0;
        tick(2);
        chk(timer_value, 32'h3, "no ticks with oscillator off");
        oscillator_enable = 1'b1;
        low_frequency_oscillator = 1'b1;
        tick(1);
        chk(timer_value, 32'h5, "low frequency step");
        low_frequency_oscillator = 1'b0;
        end_test("count");

        load_timer(32'hffff_fffe);
        tick(2);
        chk(timer_value, 32'h0, "wrap past maximum");
        tick(3);
        timer_snapshot_set = 1'b1;
        @(negedge clk_sys) timer_snapshot_set = 1'b0;
        chk(32'(snap_req), 32'h1, "snapshot request not raised");
        chk(32'(ccr[0]), 32'h1, "snapshot bit in control register");
        @(negedge clk_sys);
        chk(32'(snap_req), 32'h0, "snapshot request not cleared");
        chk(snapshot_bytes[31:0], 32'h3, "snapshot value");
        end_test("load_snapshot");

        // match programmed with events off, then enabled
        tv = 32'h0000_1234;
        load_timer(tv);
        alarm_match_regs   = tv;
        alarm_event_enable = 1'b1;
        tick(1);
        chk(32'(n_alarm), 32'h1, "one alarm pulse");
        chk(32'(ccr[3]), 32'h1, "alarm enable bit");
        chk(32'(alarm_flag), 32'h1, "alarm flag set");
        chk(32'(ccr[2]), 32'h1, "alarm flag in control register");
        alarm_event_enable = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(32'(alarm_flag), 32'h0, "flag cleared by disable");
        alarm_event_enable = 1'b1;
        tick(1);
        chk(32'(n_alarm), 32'h1, "no alarm off match");
        chk(timer_value, tv + 32'h2, "no auto clear when disabled");
        alarm_event_enable = 1'b0;
        alarm_match_regs   = tv + 32'h3;
        @(negedge clk_sys) alarm_event_enable = 1'b1;
        tick(2);
        chk(32'(n_alarm), 32'h2, "alarm at advanced match");
        alarm_event_enable = 1'b0;
        alarm_match_regs   = tv;
        end_test("alarm");

        load_timer(tv);
        alarm_event_enable = 1'b1;
        alarm_flag_autoclear_enable = 1'b1;
        tick(1);
        chk(32'(alarm_flag), 32'h1, "alarm with auto clear");
        tick(1);
        chk(32'(alarm_flag), 32'h0, "flag lasts one oscillator cycle");
        chk(timer_value, tv + 32'h2, "timer before auto clear");
        tick(1);
        chk(timer_value, 32'h0, "auto clear to zero");
        chk(32'(n_alarm), 32'h3, "alarm pulse count");
        alarm_event_enable = 1'b0;
        alarm_flag_autoclear_enable = 1'b0;
        end_test("autoclear");

        repeat (40) @(negedge clk_sys);
        chk(32'(fail_flag), 32'h0, "detector idle when disabled");
        missing_osc_detect_enable = 1'b1;
        repeat (MISS + 10) @(negedge clk_sys);
        chk(32'(fail_flag), 32'h1, "stall sets failure");
        chk(32'(ccr[5]), 32'h1, "failure bit in control register");
        chk(32'(ccr[6]), 32'h1, "detector enable bit");
        repeat (MISS) @(negedge clk_sys);
        chk(32'(n_fail), 32'h1, "one timeout pulse");
        missing_osc_detect_enable = 1'b0;
        osc_failure_clear = 1'b1;
        @(negedge clk_sys) osc_failure_clear = 1'b0;
        @(negedge clk_sys);
        chk(32'(fail_flag), 32'h0, "failure cleared");
        end_test("missing_osc");

        crystal_valid_in = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(32'(cv_status), 32'h1, "crystal valid status");
        chk(32'(ocr), 32'h10, "crystal valid at bit 4");
        end_test("crystal_valid");
        give_verdict();
    end

endmodule : tb_top
